//--- ofs_defines.vh
// ofs_defines.vh: register offsets, field positions, reset values, source indices, divide ratios
// assumes: included by bare name from every design file of the output rate select block
`ifndef OFS_DEFINES_VH
`define OFS_DEFINES_VH

// register offsets on the 8-bit processor port
`define OFS_ADDR_ALT_MODE 8'h4F
`define OFS_ADDR_SEL_A 8'h60
`define OFS_ADDR_SEL_B 8'h61
`define OFS_ADDR_STATUS 8'h6F

// reset values
`define OFS_RST_SEL 8'h00
`define OFS_RST_ALT 7'h00
`define OFS_RST_DATA 8'h00

// field positions
`define OFS_HI_MSB 7
`define OFS_HI_LSB 4
`define OFS_LO_MSB 3
`define OFS_LO_LSB 0
`define OFS_ALT_FIRST 0
`define OFS_ALT_SECOND 1
`define OFS_ALT_MSB 6

// number of clock sources entering the block
`define OFS_NUM_IN 9

// index of each source in the selectable source vector
`define OFS_SRC_OFF 5'h00
`define OFS_SRC_2K 5'h01
`define OFS_SRC_8K 5'h02
`define OFS_SRC_SYN2 5'h03
`define OFS_SRC_SYN1 5'h04
`define OFS_SRC_P48 5'h05
`define OFS_SRC_P16 5'h06
`define OFS_SRC_P12 5'h07
`define OFS_SRC_P8 5'h08
`define OFS_SRC_P6 5'h09
`define OFS_SRC_P4 5'h0A
`define OFS_SRC_S64 5'h0B
`define OFS_SRC_S48 5'h0C
`define OFS_SRC_S16 5'h0D
`define OFS_SRC_S8 5'h0E
`define OFS_SRC_S4 5'h0F
`define OFS_SRC_P64 5'h10
`define OFS_SRC_S20 5'h11
`define OFS_SRC_S12 5'h12
`define OFS_SRC_S10 5'h13
`define OFS_SRC_P2D5 5'h14
`define OFS_SRC_S5 5'h15
`define OFS_SRC_S2 5'h16
`define OFS_SRC_SREF 5'h17
`define OFS_SRC_PREF 5'h18
`define OFS_NUM_SRC 25

// divide ratios
`define OFS_DIV_64 7'h40
`define OFS_DIV_48 7'h30
`define OFS_DIV_20 7'h14
`define OFS_DIV_16 7'h10
`define OFS_DIV_12 7'h0C
`define OFS_DIV_10 7'h0A
`define OFS_DIV_8 7'h08
`define OFS_DIV_6 7'h06
`define OFS_DIV_5 7'h05
`define OFS_DIV_4 7'h04
`define OFS_DIV_2 7'h02
`define OFS_NUM_PDIV 7
`define OFS_NUM_SDIV 10

`endif

//--- ofs_sync.v
// ofs_sync.v: two flip-flop synchroniser for a group of pin levels
// assumes: inputs are asynchronous to clk_sys_i; only the second stage is read outside
`include "ofs_defines.vh"
`default_nettype none

module ofs_sync #(
  parameter W = 1
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] stable_ff;

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta_ff <= {W{1'b0}};
      stable_ff <= {W{1'b0}};
    end else begin
      meta_ff <= async_i;
      stable_ff <= meta_ff;
    end
  end

  assign sync_o = stable_ff;

endmodule

`default_nettype wire

//--- ofs_div.v
// ofs_div.v: divides a source clock by DIV, counting its rising edges
// assumes: edge_i is a one-cycle pulse per source rising edge, on clk_sys_i
`include "ofs_defines.vh"
`default_nettype none

module ofs_div #(
  parameter [6:0] DIV = `OFS_DIV_2
) (
  input wire clk_sys_i,
  input wire reset_i,
  input wire edge_i,
  output reg clk_o
);

  localparam [6:0] HALF = DIV >> 1;

  reg [6:0] cnt_ff;
  reg [6:0] nxt_cnt;

  always @* begin
    nxt_cnt = (cnt_ff == DIV - 7'h01) ? 7'h00 : cnt_ff + 7'h01;
  end

  // high for the first HALF (DIV/2 rounded down) edges of each DIV-edge period
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      cnt_ff <= 7'h00;
      clk_o <= 1'b0;
    end else if (edge_i) begin
      cnt_ff <= nxt_cnt;
      clk_o <= (nxt_cnt < HALF);
    end
  end

endmodule

`default_nettype wire

//--- ofs_top.v
// ofs_top.v: frequency selection for the first two output clock pins
// assumes: source clocks arrive as pins from other domains; processor port is on clk_sys_i
//
// Summary of operation
// RULE_01 - second output code in bits 7:4, first in bits 3:0 of 0x60, reset zero
// RULE_02 - each output decodes its code with its own alternate-decode mode bit
// RULE_03 - code zero disables the output and holds the pin low in both tables
// RULE_04 - standard code 1 gives 2kHz, code 2 gives 8kHz
// RULE_05 - standard code 3 gives second synthesized rate, code 4 the first
// RULE_06 - standard codes 5 to 10 give primary pll divided by 48,16,12,8,6,4
// RULE_07 - standard codes 11 to 15 give secondary pll divided by 64,48,16,8,4
// RULE_08 - alternate 1 primary/64, 2 secondary/20, 3 secondary/12
// RULE_09 - first output alternate 4 secondary/10, 5 primary second pll/5
// RULE_10 - second output alternate 6 gives secondary pll divided by 2
// RULE_11 - alternate 7 secondary selected reference, 8 primary selected reference
// RULE_12 - software must not program alternate codes 9 to 15
// RULE_13 - fourth output code in bits 7:4, third in bits 3:0 of 0x61, reset zero
// RULE_14 - mode register 0x4F: bit 0 first output, bit 1 second, 1 is alternate
// RULE_15 - codes with no defined source drive the pin low
`include "ofs_defines.vh"
`default_nettype none

module ofs_top (
  input wire clk_sys_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  input wire rate_2k_i,
  input wire rate_8k_i,
  input wire first_synth_rate_i,
  input wire second_synth_rate_i,
  input wire primary_path_analog_pll_i,
  input wire secondary_path_analog_pll_i,
  input wire primary_path_second_pll_i,
  input wire secondary_sel_ref_i,
  input wire primary_sel_ref_i,
  output reg first_output_clock_pin_o,
  output reg second_output_clock_pin_o
);

  // input bit positions inside the synchronised group
  localparam IN_2K = 0;
  localparam IN_8K = 1;
  localparam IN_SYN1 = 2;
  localparam IN_SYN2 = 3;
  localparam IN_PRI = 4;
  localparam IN_SEC = 5;
  localparam IN_PRI2 = 6;
  localparam IN_SREF = 7;
  localparam IN_PREF = 8;

  // primary pll divide ratio by divider slot
  function [6:0] pri_div;
    input integer idx;
    begin
      case (idx)
        0: pri_div = `OFS_DIV_48;
        1: pri_div = `OFS_DIV_16;
        2: pri_div = `OFS_DIV_12;
        3: pri_div = `OFS_DIV_8;
        4: pri_div = `OFS_DIV_6;
        5: pri_div = `OFS_DIV_4;
        default: pri_div = `OFS_DIV_64;
      endcase
    end
  endfunction

  // secondary pll divide ratio by divider slot
  function [6:0] sec_div;
    input integer idx;
    begin
      case (idx)
        0: sec_div = `OFS_DIV_64;
        1: sec_div = `OFS_DIV_48;
        2: sec_div = `OFS_DIV_16;
        3: sec_div = `OFS_DIV_8;
        4: sec_div = `OFS_DIV_4;
        5: sec_div = `OFS_DIV_20;
        6: sec_div = `OFS_DIV_12;
        7: sec_div = `OFS_DIV_10;
        8: sec_div = `OFS_DIV_5;
        default: sec_div = `OFS_DIV_2;
      endcase
    end
  endfunction

  // maps a selection code to a source index; is_second picks the second output's table
  function [4:0] ofs_decode;
    input [3:0] code;
    input alt;
    input is_second;
    begin
      if (!alt) begin
        case (code)
          4'h0: ofs_decode = `OFS_SRC_OFF; // RULE_03
          4'h1: ofs_decode = `OFS_SRC_2K; // RULE_04
          4'h2: ofs_decode = `OFS_SRC_8K; // RULE_04
          4'h3: ofs_decode = `OFS_SRC_SYN2; // RULE_05
          4'h4: ofs_decode = `OFS_SRC_SYN1; // RULE_05
          4'h5: ofs_decode = `OFS_SRC_P48; // RULE_06
          4'h6: ofs_decode = `OFS_SRC_P16; // RULE_06
          4'h7: ofs_decode = `OFS_SRC_P12; // RULE_06
          4'h8: ofs_decode = `OFS_SRC_P8; // RULE_06
          4'h9: ofs_decode = `OFS_SRC_P6; // RULE_06
          4'hA: ofs_decode = `OFS_SRC_P4; // RULE_06
          4'hB: ofs_decode = `OFS_SRC_S64; // RULE_07
          4'hC: ofs_decode = `OFS_SRC_S48; // RULE_07
          4'hD: ofs_decode = `OFS_SRC_S16; // RULE_07
          4'hE: ofs_decode = `OFS_SRC_S8; // RULE_07
          default: ofs_decode = `OFS_SRC_S4; // RULE_07
        endcase
      end else begin
        case (code)
          4'h0: ofs_decode = `OFS_SRC_OFF; // RULE_03
          4'h1: ofs_decode = `OFS_SRC_P64; // RULE_08
          4'h2: ofs_decode = `OFS_SRC_S20; // RULE_08
          4'h3: ofs_decode = `OFS_SRC_S12; // RULE_08
          4'h4: ofs_decode = `OFS_SRC_S10; // RULE_09
          4'h5: ofs_decode = is_second ? `OFS_SRC_S5 : `OFS_SRC_P2D5; // RULE_09
          4'h6: ofs_decode = is_second ? `OFS_SRC_S2 : `OFS_SRC_OFF; // RULE_10 RULE_15
          4'h7: ofs_decode = `OFS_SRC_SREF; // RULE_11
          4'h8: ofs_decode = `OFS_SRC_PREF; // RULE_11
          default: ofs_decode = `OFS_SRC_OFF; // RULE_15
        endcase
      end
    end
  endfunction

  // flags a code that selects no defined source
  function ofs_undef;
    input [3:0] code;
    input alt;
    input is_second;
    begin
      ofs_undef = 1'b0;
      if (alt) begin
        case (code)
          4'h6: ofs_undef = !is_second; // RULE_15
          4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: ofs_undef = 1'b1; // RULE_15
          default: ofs_undef = 1'b0;
        endcase
      end
    end
  endfunction

  // configuration registers
  reg [7:0] sel_a_ff;
  reg [7:0] sel_b_ff;
  reg [`OFS_ALT_MSB:0] alt_mode_ff;
  reg [7:0] nxt_rdata;

  // source synchronisation and edge detection
  wire [`OFS_NUM_IN-1:0] src_raw;
  wire [`OFS_NUM_IN-1:0] src_sync;
  reg [`OFS_NUM_IN-1:0] src_prev_ff;
  wire [`OFS_NUM_IN-1:0] src_rise;
  wire [`OFS_NUM_PDIV-1:0] pri_clk;
  wire [`OFS_NUM_SDIV-1:0] sec_clk;
  wire pri2_div5_clk;
  wire [`OFS_NUM_SRC-1:0] src_vec;

  // decode results
  wire [3:0] first_output_rate_sel;
  wire [3:0] second_output_rate_sel;
  wire [3:0] third_output_rate_sel;
  wire [3:0] fourth_output_rate_sel;
  wire first_output_alt_decode;
  wire second_output_alt_decode;
  wire [4:0] first_idx;
  wire [4:0] second_idx;
  wire first_undef;
  wire second_undef;
  reg nxt_first_pin;
  reg nxt_second_pin;

  assign first_output_rate_sel = sel_a_ff[`OFS_LO_MSB:`OFS_LO_LSB]; // RULE_01
  assign second_output_rate_sel = sel_a_ff[`OFS_HI_MSB:`OFS_HI_LSB]; // RULE_01
  assign third_output_rate_sel = sel_b_ff[`OFS_LO_MSB:`OFS_LO_LSB]; // RULE_13
  assign fourth_output_rate_sel = sel_b_ff[`OFS_HI_MSB:`OFS_HI_LSB]; // RULE_13
  assign first_output_alt_decode = alt_mode_ff[`OFS_ALT_FIRST]; // RULE_14
  assign second_output_alt_decode = alt_mode_ff[`OFS_ALT_SECOND]; // RULE_14

  assign src_raw[IN_2K] = rate_2k_i;
  assign src_raw[IN_8K] = rate_8k_i;
  assign src_raw[IN_SYN1] = first_synth_rate_i;
  assign src_raw[IN_SYN2] = second_synth_rate_i;
  assign src_raw[IN_PRI] = primary_path_analog_pll_i;
  assign src_raw[IN_SEC] = secondary_path_analog_pll_i;
  assign src_raw[IN_PRI2] = primary_path_second_pll_i;
  assign src_raw[IN_SREF] = secondary_sel_ref_i;
  assign src_raw[IN_PREF] = primary_sel_ref_i;

  ofs_sync #(
    .W(`OFS_NUM_IN)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i(src_raw),
    .sync_o(src_sync)
  );

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      src_prev_ff <= {`OFS_NUM_IN{1'b0}};
    end else begin
      src_prev_ff <= src_sync;
    end
  end

  assign src_rise = src_sync & ~src_prev_ff;

  // primary pll dividers
  genvar gi;
  generate
    for (gi = 0; gi < `OFS_NUM_PDIV; gi = gi + 1) begin : g_pdiv
      ofs_div #(
        .DIV(pri_div(gi))
      ) u_div (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .edge_i(src_rise[IN_PRI]),
        .clk_o(pri_clk[gi])
      );
    end
    // secondary pll dividers
    for (gi = 0; gi < `OFS_NUM_SDIV; gi = gi + 1) begin : g_sdiv
      ofs_div #(
        .DIV(sec_div(gi))
      ) u_div (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .edge_i(src_rise[IN_SEC]),
        .clk_o(sec_clk[gi])
      );
    end
  endgenerate

  ofs_div #(
    .DIV(`OFS_DIV_5)
  ) u_pri2_div5 (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .edge_i(src_rise[IN_PRI2]),
    .clk_o(pri2_div5_clk)
  );

  // selectable source vector, indexed by decoded source number
  assign src_vec[`OFS_SRC_OFF] = 1'b0; // RULE_03
  assign src_vec[`OFS_SRC_2K] = src_sync[IN_2K]; // RULE_04
  assign src_vec[`OFS_SRC_8K] = src_sync[IN_8K]; // RULE_04
  assign src_vec[`OFS_SRC_SYN2] = src_sync[IN_SYN2]; // RULE_05
  assign src_vec[`OFS_SRC_SYN1] = src_sync[IN_SYN1]; // RULE_05
  assign src_vec[10:5] = pri_clk[5:0]; // RULE_06
  assign src_vec[15:11] = sec_clk[4:0]; // RULE_07
  assign src_vec[`OFS_SRC_P64] = pri_clk[6]; // RULE_08
  assign src_vec[`OFS_SRC_S20] = sec_clk[5]; // RULE_08
  assign src_vec[`OFS_SRC_S12] = sec_clk[6]; // RULE_08
  assign src_vec[`OFS_SRC_S10] = sec_clk[7]; // RULE_09
  assign src_vec[`OFS_SRC_P2D5] = pri2_div5_clk; // RULE_09
  assign src_vec[`OFS_SRC_S5] = sec_clk[8];
  assign src_vec[`OFS_SRC_S2] = sec_clk[9]; // RULE_10
  assign src_vec[`OFS_SRC_SREF] = src_sync[IN_SREF]; // RULE_11
  assign src_vec[`OFS_SRC_PREF] = src_sync[IN_PREF]; // RULE_11

  // per-output decode with its own mode bit
  assign first_idx = ofs_decode(first_output_rate_sel, first_output_alt_decode, 1'b0); // RULE_02
  assign second_idx = ofs_decode(second_output_rate_sel, second_output_alt_decode, 1'b1); // RULE_02
  assign first_undef = ofs_undef(first_output_rate_sel, first_output_alt_decode, 1'b0);
  assign second_undef = ofs_undef(second_output_rate_sel, second_output_alt_decode, 1'b1);

  // next pin levels; undefined codes force the pin low
  always @* begin
    nxt_first_pin = src_vec[first_idx];
    nxt_second_pin = src_vec[second_idx];
    if (first_undef) begin
      nxt_first_pin = 1'b0; // RULE_15
    end
    if (second_undef) begin
      nxt_second_pin = 1'b0; // RULE_15
    end
  end

  // output pins
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      first_output_clock_pin_o <= 1'b0; // RULE_03
      second_output_clock_pin_o <= 1'b0; // RULE_03
    end else begin
      first_output_clock_pin_o <= nxt_first_pin; // RULE_02
      second_output_clock_pin_o <= nxt_second_pin; // RULE_02
    end
  end

  // register writes
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sel_a_ff <= `OFS_RST_SEL; // RULE_01
      sel_b_ff <= `OFS_RST_SEL; // RULE_13
      alt_mode_ff <= `OFS_RST_ALT; // RULE_14
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `OFS_ADDR_SEL_A: begin
          sel_a_ff <= reg_wdata_i; // RULE_01
        end
        `OFS_ADDR_SEL_B: begin
          sel_b_ff <= reg_wdata_i; // RULE_13
        end
        `OFS_ADDR_ALT_MODE: begin
          alt_mode_ff <= reg_wdata_i[`OFS_ALT_MSB:0]; // RULE_14
        end
        default: begin
          alt_mode_ff <= alt_mode_ff;
        end
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    nxt_rdata = `OFS_RST_DATA;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `OFS_ADDR_SEL_A: nxt_rdata = sel_a_ff;
        `OFS_ADDR_SEL_B: nxt_rdata = sel_b_ff;
        `OFS_ADDR_ALT_MODE: nxt_rdata = {1'b0, alt_mode_ff};
        `OFS_ADDR_STATUS: nxt_rdata = {4'h0, second_undef, first_undef,
                                       second_output_clock_pin_o, first_output_clock_pin_o};
        default: nxt_rdata = `OFS_RST_DATA;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      reg_rdata_o <= `OFS_RST_DATA;
    end else begin
      reg_rdata_o <= nxt_rdata;
    end
  end

endmodule

`default_nettype wire

//--- ofs_top_props.sv
// ofs_top_props.sv: port level assertions for ofs_top
// assumes: bound to ofs_top; register writes are mirrored from the port
`default_nettype none
module ofs_top_props (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic rate_2k_i,
  input wire logic secondary_sel_ref_i,
  input wire logic first_output_clock_pin_o,
  input wire logic second_output_clock_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sel_a_ff, sel_b_ff, mode_ff;
  logic [2:0] settle_ff;
  logic low1, low2, pin1, pin2;
  assign pin1 = first_output_clock_pin_o;
  assign pin2 = second_output_clock_pin_o;
  assign low1 = sel_a_ff[3:0] == 4'h0 ||
    (mode_ff[0] && (sel_a_ff[3:0] > 4'h8 || sel_a_ff[3:0] == 4'h6));
  assign low2 = sel_a_ff[7:4] == 4'h0 || (mode_ff[1] && sel_a_ff[7:4] > 4'h8);
  // settle counts cycles since the last write to 0x60 or 0x4F, saturating at 7
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      sel_a_ff <= 8'h00;
      sel_b_ff <= 8'h00;
      mode_ff <= 8'h00;
      settle_ff <= 3'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == 8'h60) sel_a_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h61) sel_b_ff <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == 8'h4F) mode_ff <= {1'b0, reg_wdata_i[6:0]};
      if (reg_wr_i && (reg_addr_i == 8'h60 || reg_addr_i == 8'h4F)) settle_ff <= 3'h0;
      else if (settle_ff != 3'h7) settle_ff <= settle_ff + 3'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  AST_RESET_OUT: assert property ($fell(reset_i) |-> !pin1 && !pin2 && reg_rdata_o == 8'h00)
    else $error("outputs not cleared by reset");
  AST_RD_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero when idle");
  AST_RD_A: assert property (reg_rd_i && reg_addr_i == 8'h60 |=> reg_rdata_o == $past(sel_a_ff))
    else $error("first select register read wrong");
  AST_RD_B: assert property (reg_rd_i && reg_addr_i == 8'h61 |=> reg_rdata_o == $past(sel_b_ff))
    else $error("second select register read wrong");
  AST_RD_MODE: assert property (reg_rd_i && reg_addr_i == 8'h4F |=> reg_rdata_o == $past(mode_ff))
    else $error("mode register read wrong");
  AST_LOW1: assert property (settle_ff > 3'h3 && low1 |-> !pin1)
    else $error("first output not held low");
  AST_LOW2: assert property (settle_ff > 3'h3 && low2 |-> !pin2)
    else $error("second output not held low");
  AST_PASS1: assert property (settle_ff > 3'h3 && !mode_ff[0] && sel_a_ff[3:0] == 4'h1 |->
    pin1 == $past(rate_2k_i, 3)) else $error("first output does not follow 2k source");
  AST_PASS2: assert property (settle_ff > 3'h3 && mode_ff[1] && sel_a_ff[7:4] == 4'h7 |->
    pin2 == $past(secondary_sel_ref_i, 3)) else $error("second output does not follow reference");
  cover property (mode_ff[0] && sel_a_ff[3:0] == 4'h5 && $rose(pin1));
  cover property (!mode_ff[1] && sel_a_ff[7:4] == 4'hF && $rose(pin2));
  cover property (reg_rd_i && reg_addr_i == 8'h61);
endmodule
bind ofs_top ofs_top_props u_props (.*);
`default_nettype wire

//--- ofs_src_model.sv
// ofs_src_model.sv: free running source clocks feeding the selector
// assumes: half periods in system clock cycles, each at least 2
`default_nettype none
module ofs_src_model #(
  parameter int HP [9] = '{2, 2, 2, 2, 2, 2, 2, 2, 2}
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  output var logic [8:0] src_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt [9];
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < 9; i++) begin
      if (reset_i || cnt[i] == HP[i] - 1) cnt[i] <= 0;
      else cnt[i] <= cnt[i] + 1;
      if (reset_i) src_o[i] <= 1'b0;
      else if (cnt[i] == HP[i] - 1) src_o[i] <= ~src_o[i];
    end
  end
endmodule
`default_nettype wire

//--- test_output_clock_freq_select.sv
// test_output_clock_freq_select.sv: self-checking bench for ofs_top
// assumes: ofs_src_model drives all sources; ofs_top_props is bound to the design
`default_nettype none
module test_output_clock_freq_select;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HP [9] = '{20, 6, 4, 7, 3, 2, 5, 9, 11};
  localparam int WIN = 576;
  // source index and divisor per code: standard, alternate first, alternate second
  localparam int SS [16] = '{-1, 0, 1, 3, 2, 4, 4, 4, 4, 4, 4, 5, 5, 5, 5, 5};
  localparam int SD [16] = '{1, 1, 1, 1, 1, 48, 16, 12, 8, 6, 4, 64, 48, 16, 8, 4};
  localparam int AS1 [16] = '{-1, 4, 5, 5, 5, 6, -1, 7, 8, -1, -1, -1, -1, -1, -1, -1};
  localparam int AS2 [16] = '{-1, 4, 5, 5, 5, 5, 5, 7, 8, -1, -1, -1, -1, -1, -1, -1};
  localparam int AD [16] = '{1, 64, 20, 12, 10, 5, 2, 1, 1, 1, 1, 1, 1, 1, 1, 1};
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  wire logic [7:0] reg_rdata_o;
  wire logic [8:0] src;
  wire logic pin1;
  wire logic pin2;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int model [256];
  always #20 clk_sys_i = ~clk_sys_i;
  ofs_src_model #(.HP(HP)) u_src (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .src_o(src));
  ofs_top u_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rate_2k_i(src[0]), .rate_8k_i(src[1]),
    .first_synth_rate_i(src[2]), .second_synth_rate_i(src[3]),
    .primary_path_analog_pll_i(src[4]), .secondary_path_analog_pll_i(src[5]),
    .primary_path_second_pll_i(src[6]), .secondary_sel_ref_i(src[7]),
    .primary_sel_ref_i(src[8]), .first_output_clock_pin_o(pin1),
    .second_output_clock_pin_o(pin2));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
    if (a == 8'h60 || a == 8'h61) model[a] = d;
    if (a == 8'h4F) model[a] = d & 8'h7F;
  endtask
  task automatic rd_chk(input logic [7:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    if (a == 8'h6F) check("status upper bits", 0, {24'h0, reg_rdata_o & 8'hF0});
    else check("register read", model[a], {24'h0, reg_rdata_o});
    @(posedge clk_sys_i);
  endtask
  task automatic idle();
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  function automatic int exp_edges(int o, int m, int c);
    int s;
    int d;
    s = m == 0 ? SS[c] : (o == 0 ? AS1[c] : AS2[c]);
    d = m == 0 ? SD[c] : AD[c];
    return s < 0 ? 0 : WIN / (2 * HP[s] * d);
  endfunction
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 45000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    logic [7:0] addrs [5];
    int o, m, c, e, n;
    logic prev, pin;
    logic [7:0] a, d;
    addrs = '{8'h4F, 8'h60, 8'h61, 8'h6F, 8'h55};
    void'($urandom(63603));
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd_chk(8'h60);
    rd_chk(8'h61);
    rd_chk(8'h4F);
    for (int i = 0; i < 24; i++) begin
      a = addrs[$urandom_range(4, 0)];
      d = 8'($urandom);
      if (a == 8'h60) d = d & 8'h77;
      wr(a, d);
      rd_chk(addrs[$urandom_range(4, 0)]);
    end
    idle();
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    model = '{default: 0};
    rd_chk(8'h60);
    rd_chk(8'h61);
    for (int k = 0; k < 64; k++) begin
      o = k / 32;
      m = (k / 16) % 2;
      c = k % 16;
      if (m == 1 && c > 8) continue;
      wr(8'h4F, 8'(m * 3));
      wr(8'h60, o == 0 ? 8'(c) : 8'(c * 16));
      rd_chk(8'h60);
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      prev = o == 0 ? pin1 : pin2;
      n = 0;
      repeat (WIN) begin
        @(negedge clk_sys_i);
        pin = o == 0 ? pin1 : pin2;
        if (pin && !prev) n++;
        prev = pin;
      end
      @(posedge clk_sys_i);
      e = exp_edges(o, m, c);
      if (n >= e - 1 && n <= e + 1 && (e > 0 || n == 0)) n = e;
      if (m == 0) check("standard edges", e, n);
      else check("alternate edges", e, n);
    end
    stop_test();
  end
endmodule
`default_nettype wire
